/* File: design/rsl_synth.v */
// Two integer-N synthesiser dividers with register sets, phase detect and lock detect
// Function
// RULE_01: Each synthesiser stores two independent N/R sets; either may drive dividers.
// RULE_02: One control write swaps a synthesiser between its stored sets.
// RULE_03: Feedback counter is 20 bits, reference counter 13 bits, per synthesiser.
// RULE_04: Reference divided by R, VCO divided by N, compared in phase.
// RULE_05: Four data writes program one synthesiser; partial values act meanwhile.
// RULE_06: Host rewrites a set only when idle or on alternate; no interlock.
// RULE_07: Control register select fields pick the active set per synthesiser.
// RULE_08: Gain bits 3 and 11 pick high or low pump current.
// RULE_09: Host picks R for a 2.5kHz to 200kHz comparison step.
// RULE_10: Both synthesisers run from the shared baseband reference clock.
// RULE_11: Lock bits readable in status register and raise masked interrupt.
// RULE_12: Locked to out-of-lock transition is flagged as an interrupt event.
// RULE_13: Lock tolerance is one or four undivided reference clock periods.
// RULE_14: Three-deep measurement history, lock reported by majority vote.
// RULE_15: Lock needs two consecutive good measurements; phase lock only. Code locks on any two good of the last three.
// RULE_16: Lost-lock flag holds until status read; interrupt holds while unmasked flag.
`timescale 1ns/10ps
`default_nettype none
`include "rsl_defs.vh"
module rsl_synth #(
   parameter N_W = `RSL_N_W,
   parameter R_W = `RSL_R_W
) (
   input wire core_clk,
   input wire resetn,
   input wire wr_en,
   input wire rd_en,
   input wire [7:0] addr,
   input wire [15:0] wr_data,
   output reg [7:0] rd_data,
   input wire [1:0] lost_mask,
   output reg irq,
   input wire [1:0] vco_in,
   output reg [1:0] pump_up,
   output reg [1:0] pump_down,
   output reg [1:0] pump_gain_high,
   output reg [1:0] pump_enable
);
   // Core clock is the shared synth reference clock [RULE_10]
   // Release is synchronised so that no flop leaves reset on a different edge
   reg rst_s1_reg, rst_s2_reg;
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   wire rst_n = rst_s2_reg;

   // Data port word: [15] synth, [14] set, [13:12] word index, [11:0] payload.
   // Word 0: N[11:0]; word 1: N[19:12] in [7:0]; word 2: R[11:0]; word 3: R[12] in [0].
   // Control word: bit 0/8 set select, 1/9 enable, 2/10 wide tolerance, 3/11 pump gain.
   reg [15:0] ctrl_reg;
   reg [N_W-1:0] n_set_reg [0:3];
   reg [R_W-1:0] r_set_reg [0:3];
   wire [1:0] wsel = wr_data[15:14];
   wire [1:0] widx = wr_data[13:12];
   integer k;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= `RSL_CTRL_RESET;
         for (k = 0; k < 4; k = k + 1) begin
            n_set_reg[k] <= {N_W{1'b0}};
            r_set_reg[k] <= {R_W{1'b0}};
         end
      end else if (wr_en) begin
         if (addr == `RSL_ADDR_CTRL) begin
            ctrl_reg <= wr_data; // [RULE_02] [RULE_07]
         end
         if (addr == `RSL_ADDR_DATA) begin
            // No interlock: a write to the active set takes hold at once
            // Each word lands immediately, so partial values act until word 3 [RULE_05] [RULE_06]
            case (widx)
               2'h0: n_set_reg[wsel][11:0] <= wr_data[11:0];
               2'h1: n_set_reg[wsel][N_W-1:12] <= wr_data[N_W-13:0];
               2'h2: r_set_reg[wsel][11:0] <= wr_data[11:0];
               default: r_set_reg[wsel][R_W-1:12] <= wr_data[R_W-13:0];
            endcase
         end
      end
   end

   // Vco inputs are asynchronous; two flops then edge detect
   // Reset level matches the idle level 0, so no false feedback edge follows reset
   reg [1:0] vco_s1_reg, vco_s2_reg, vco_s3_reg;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         vco_s1_reg <= 2'h0;
         vco_s2_reg <= 2'h0;
         vco_s3_reg <= 2'h0;
      end else begin
         vco_s1_reg <= vco_in;
         vco_s2_reg <= vco_s1_reg;
         vco_s3_reg <= vco_s2_reg;
      end
   end
   wire [1:0] vco_rise = vco_s2_reg & ~vco_s3_reg;

   wire [1:0] lock_vote;
   wire [1:0] lost_event;
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : ch
         wire sel = ctrl_reg[8*g + `RSL_CTRL_SEL0]; // [RULE_01] [RULE_07]
         wire en = ctrl_reg[8*g + `RSL_CTRL_EN0];
         // Wide tolerance suits a fast reference, where a period of skew is normal [RULE_13]
         wire [2:0] tol = ctrl_reg[8*g + `RSL_CTRL_TOL0] ? `RSL_TOL_WIDE : `RSL_TOL_NARROW;
         localparam [1:0] SET_BASE = 2 * g;
         wire [1:0] set_idx = SET_BASE | {1'b0, sel};
         wire [N_W-1:0] n_val = n_set_reg[set_idx];
         wire [R_W-1:0] r_val = r_set_reg[set_idx];
         reg [N_W-1:0] n_cnt_reg; // [RULE_03]
         reg [R_W-1:0] r_cnt_reg; // [RULE_03]
         reg ref_pend_reg, vco_pend_reg;
         reg [2:0] skew_reg;
         reg [2:0] hist_reg;
         reg vote_reg;
         // Terminal count compares count plus one, so values 0 and 1 both divide by one
         wire r_tc = (r_cnt_reg + 1'b1 >= r_val);
         wire n_tc = vco_rise[g] && (n_cnt_reg + 1'b1 >= n_val);
         wire both = (ref_pend_reg | r_tc) & (vco_pend_reg | n_tc);
         wire meas_done = en & both;
         // Good when both edges land together or the lagging one is within tolerance
         wire in_tol = (ref_pend_reg == vco_pend_reg) ? 1'b1 : (skew_reg < tol);
         wire [2:0] hist_next = {hist_reg[1:0], in_tol};
         // Majority of three; needs two good ones so a single hit never locks [RULE_14] [RULE_15]
         wire vote_next = (hist_next[0] & hist_next[1]) | (hist_next[0] & hist_next[2]) |
            (hist_next[1] & hist_next[2]);
         always @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               n_cnt_reg <= {N_W{1'b0}};
               r_cnt_reg <= {R_W{1'b0}};
               ref_pend_reg <= 1'b0;
               vco_pend_reg <= 1'b0;
               skew_reg <= 3'h0;
               hist_reg <= 3'h0;
               vote_reg <= 1'b0;
            end else if (!en) begin
               // Disable clears the history, so a re-enabled loop must earn lock again
               n_cnt_reg <= {N_W{1'b0}};
               r_cnt_reg <= {R_W{1'b0}};
               ref_pend_reg <= 1'b0;
               vco_pend_reg <= 1'b0;
               skew_reg <= 3'h0;
               hist_reg <= 3'h0;
               vote_reg <= 1'b0;
            end else begin
               // Reference divided by R, VCO divided by N [RULE_04]
               r_cnt_reg <= r_tc ? {R_W{1'b0}} : r_cnt_reg + 1'b1;
               if (vco_rise[g]) begin
                  n_cnt_reg <= n_tc ? {N_W{1'b0}} : n_cnt_reg + 1'b1;
               end
               if (meas_done) begin
                  ref_pend_reg <= 1'b0;
                  vco_pend_reg <= 1'b0;
                  skew_reg <= 3'h0;
                  hist_reg <= hist_next; // [RULE_14]
                  vote_reg <= vote_next;
               end else begin
                  ref_pend_reg <= ref_pend_reg | r_tc;
                  vco_pend_reg <= vco_pend_reg | n_tc;
                  // Skew counted in undivided reference periods, saturating [RULE_13]
                  // Saturation keeps a wide skew from wrapping back into tolerance
                  if ((ref_pend_reg | vco_pend_reg) && skew_reg != 3'h7) begin
                     skew_reg <= skew_reg + 1'b1;
                  end
               end
            end
         end
         assign lock_vote[g] = vote_reg; // [RULE_11]
         assign lost_event[g] = vote_reg & ~vote_next & meas_done; // [RULE_12]
         // The leading edge drives its pump until the lagging edge arrives
         always @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               pump_up[g] <= 1'b0;
               pump_down[g] <= 1'b0;
               pump_gain_high[g] <= 1'b0;
               pump_enable[g] <= 1'b0;
            end else begin
               pump_up[g] <= en & ref_pend_reg & ~vco_pend_reg;
               pump_down[g] <= en & vco_pend_reg & ~ref_pend_reg;
               pump_gain_high[g] <= ctrl_reg[8*g + `RSL_CTRL_GAIN0]; // [RULE_08]
               pump_enable[g] <= en;
            end
         end
      end
   endgenerate

   // Lost flags: set wins over read-clear [RULE_16]
   // A flag set in the cycle of its read stays set and shows on the next read
   reg [1:0] lost_reg;
   wire stat_rd = rd_en && (addr == `RSL_ADDR_STAT);
   wire [1:0] lost_next = (stat_rd ? 2'h0 : lost_reg) | lost_event;
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lost_reg <= 2'h0;
      end else begin
         lost_reg <= lost_next; // [RULE_12] [RULE_16]
      end
   end

   // Read data holds between strobes so a slow host can take it late
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         if (addr == `RSL_ADDR_STAT) begin
            rd_data <= {2'h0, lost_reg, 2'h0, lock_vote}; // [RULE_11]
         end else begin
            rd_data <= 8'h00;
         end
      end
   end

   // Irq follows the flags as they land; a mask change shows one cycle later
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(lost_next & ~lost_mask); // [RULE_11] [RULE_16]
      end
   end
endmodule // rsl_synth
`default_nettype wire

/* File: design/rsl_defs.vh */
// Constants for the synthesiser divider and lock detect block
`ifndef RSL_DEFS_VH
`define RSL_DEFS_VH
`define RSL_ADDR_DATA 8'hB2
`define RSL_ADDR_CTRL 8'hB3
`define RSL_ADDR_STAT 8'hB4
`define RSL_N_W 20
`define RSL_R_W 13
`define RSL_CTRL_SEL0 0
`define RSL_CTRL_EN0 1
`define RSL_CTRL_TOL0 2
`define RSL_CTRL_GAIN0 3
`define RSL_CTRL_SEL1 8
`define RSL_CTRL_EN1 9
`define RSL_CTRL_TOL1 10
`define RSL_CTRL_GAIN1 11
`define RSL_CTRL_RESET 16'h0000
`define RSL_STAT_LOCK0 0
`define RSL_STAT_LOCK1 1
`define RSL_STAT_LOST0 4
`define RSL_STAT_LOST1 5
`define RSL_TOL_NARROW 3'h1
`define RSL_TOL_WIDE 3'h4
`define RSL_WORDS_PER_LOAD 2'h3
`endif

/* File: testbench/rsl_chk.sv */
// Port-level assertions for the synthesiser divider block
`timescale 1ns/10ps
`default_nettype none
module rsl_chk (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] addr,
   input wire logic [15:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic [1:0] lost_mask,
   input wire logic irq,
   input wire logic [1:0] vco_in,
   input wire logic [1:0] pump_up,
   input wire logic [1:0] pump_down,
   input wire logic [1:0] pump_gain_high,
   input wire logic [1:0] pump_enable
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic wc = wr_en && addr == 8'hB3;
   wire logic rs = rd_en && addr == 8'hB4;
   chk_gain_apply: assert property (wc ##1 !wc |=> pump_gain_high ==
      {$past(wr_data[11], 2), $past(wr_data[3], 2)}) else $error("gain not applied");
   chk_cfg_hold: assert property (!wc ##1 !wc |=>
      $stable(pump_gain_high) && $stable(pump_enable)) else $error("control moved");
   chk_rd_unmap: assert property (rd_en && addr != 8'hB4 ##1 !rd_en |=>
      rd_data == 8'h00) else $error("unmapped read not zero");
   chk_rd_hold: assert property (!rd_en ##1 !rd_en |=> $stable(rd_data))
      else $error("read data moved");
   chk_rd_spare: assert property (rd_en ##1 !rd_en |=> rd_data[7:6] == 2'h0 &&
      rd_data[3:2] == 2'h0) else $error("spare status bits set");
   chk_irq_masked: assert property (lost_mask == 2'h3 ##1 lost_mask == 2'h3 |->
      !irq) else $error("masked irq");
   chk_irq_rise: assert property ($rose(irq) |-> $past(lost_mask) != 2'h3)
      else $error("irq rose while masked");
   chk_irq_hold: assert property (irq && !rs && !$past(rs) && lost_mask == 2'h0 |=> irq)
      else $error("irq dropped without read");
   chk_pump_excl: assert property ((pump_up & pump_down) == 2'h0)
      else $error("pump up and down together");
   chk_pump_gate: assert property ((~pump_enable & (pump_up | pump_down)) == 2'h0)
      else $error("pump active while disabled");
   cover property (wc);
   cover property (rs ##2 rd_data[0]);
   cover property ($rose(irq));
   cover property (pump_up[0] ##1 pump_up[0]);
   cover property (pump_down[1]);
endmodule // rsl_chk
bind rsl_synth rsl_chk i_chk (.core_clk, .resetn, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
   .lost_mask, .irq, .vco_in, .pump_up, .pump_down, .pump_gain_high, .pump_enable);
`default_nettype wire

/* File: testbench/rsl_vco_model.sv */
// Behavioural VCO pair whose phase is slewed by the pump outputs
`timescale 1ns/10ps
`default_nettype none
module rsl_vco_model #(
   parameter int P = 16
) (
   input wire logic clk,
   input wire logic [1:0] run,
   input wire logic [1:0] up,
   input wire logic [1:0] dn,
   output logic [1:0] vco
);
   int acc [2];
   initial vco = 2'h0;
   // Stands still while not running, as a powered-down oscillator would
   always @(posedge clk) begin
      for (int i = 0; i < 2; i++) begin
         acc[i] = run[i] ? (acc[i] + (up[i] ? 2 : dn[i] ? 0 : 1)) % P : 0;
         vco[i] <= run[i] && acc[i] < P / 2;
      end
   end
endmodule // rsl_vco_model
`default_nettype wire

/* File: testbench/rsl_synth_divider_lock_detect_tb.sv */
// Self-checking bench for the synthesiser divider block
`timescale 1ns/10ps
`default_nettype none
`include "rsl_defs.vh"
module rsl_synth_divider_lock_detect_tb;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wr_data = 16'h0000;
   logic [1:0] lost_mask = 2'h0;
   logic [1:0] run = 2'h0;
   logic [7:0] st;
   int checks = 0;
   int miscompares = 0;
   wire logic [7:0] rd_data;
   wire logic irq;
   wire logic [1:0] vco_in, pump_up, pump_down, gain, en;
   always #25 core_clk = ~core_clk;
   rsl_synth i_dut (.core_clk(core_clk), .resetn(resetn), .wr_en(wr_en), .rd_en(rd_en),
      .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .lost_mask(lost_mask), .irq(irq),
      .vco_in(vco_in), .pump_up(pump_up), .pump_down(pump_down), .pump_gain_high(gain),
      .pump_enable(en));
   // Oscillator free-runs at 100 reference periods, matching R 100 at N 1
   rsl_vco_model #(.P(100)) i_vco (.clk(core_clk), .run(run), .up(pump_up), .dn(pump_down),
      .vco(vco_in));
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(negedge core_clk);
      wr_en = 1'b1;
      addr = a;
      wr_data = d;
      idle(1);
      wr_en = 1'b0;
   endtask
   // Samples a cycle late; read data stands until the next strobe
   task automatic rd(input logic [7:0] a);
      @(negedge core_clk);
      rd_en = 1'b1;
      addr = a;
      idle(1);
      rd_en = 1'b0;
      idle(1);
      st = rd_data;
   endtask
   task automatic t_ctrl;
      chk("gain", gain, 16'h0000);
      wr(`RSL_ADDR_CTRL, 16'h0808);
      idle(2);
      chk("gain", gain, 16'h0003);
      chk("enable", en, 16'h0000);
      chk("pump_idle", pump_up | pump_down, 16'h0000);
      wr(`RSL_ADDR_CTRL, 16'h0800);
      idle(2);
      chk("gain", gain, 16'h0002);
      rd(8'h5A);
      chk("unmapped", st, 16'h0000);
   endtask
   // Set 0 locks at N 1, R 100, a 200 kHz step; set 1 asks N 8, beyond the oscillator's reach
   task automatic t_lock;
      logic [15:0] w [8] = '{16'h0001, 16'h1000, 16'h2064, 16'h3000,
         16'h4008, 16'h5000, 16'h6064, 16'h7000};
      foreach (w[i]) wr(`RSL_ADDR_DATA, w[i]);
      run = 2'h1;
      wr(`RSL_ADDR_CTRL, 16'h0007);
      idle(600);
      rd(`RSL_ADDR_STAT);
      chk("lock_alt", st[0], 16'h0000);
      wr(`RSL_ADDR_CTRL, 16'h0006);
      rd(`RSL_ADDR_STAT);
      chk("lock_early", st[0], 16'h0000);
      for (int i = 0; i < 300 && st[0] !== 1'b1; i++) rd(`RSL_ADDR_STAT);
      chk("lock", st[0], 16'h0001);
   endtask
   task automatic t_lost;
      logic seen_up;
      seen_up = 1'b0;
      wr(`RSL_ADDR_CTRL, 16'h0007);
      rd(`RSL_ADDR_STAT);
      chk("lock_vote", st[0], 16'h0001);
      // Two bad measurements of about 400 cycles each are needed to outvote the lock
      for (int i = 0; i < 1500 && irq !== 1'b1; i++) begin
         idle(1);
         seen_up = seen_up | pump_up[0];
      end
      chk("pump_up", seen_up, 16'h0001);
      chk("irq_set", irq, 16'h0001);
      lost_mask = 2'h1;
      idle(2);
      chk("irq_mask", irq, 16'h0000);
      lost_mask = 2'h0;
      idle(2);
      chk("irq_held", irq, 16'h0001);
      rd(`RSL_ADDR_STAT);
      chk("status", st, 16'h0010);
      chk("irq_clear", irq, 16'h0000);
      rd(`RSL_ADDR_STAT);
      chk("status", st, 16'h0000);
   endtask
   // Synth 1 at N 1, R 4095: the oscillator edge leads, so the pump must pull down
   task automatic t_pump;
      logic seen_dn;
      seen_dn = 1'b0;
      wr(`RSL_ADDR_DATA, 16'h8001);
      wr(`RSL_ADDR_DATA, 16'hAFFF);
      run = 2'h3;
      wr(`RSL_ADDR_CTRL, 16'h0207);
      for (int i = 0; i < 300 && seen_dn !== 1'b1; i++) begin
         idle(1);
         seen_dn = pump_down[1];
      end
      chk("pump_down", seen_dn, 16'h0001);
      chk("pump_on", en, 16'h0003);
      rd(`RSL_ADDR_STAT);
      chk("lock1", st[1], 16'h0000);
   endtask
   task end_of_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      #400000;
      miscompares++;
      end_of_test;
   end
   initial begin
      idle(10);
      resetn = 1'b1;
      idle(3);
      t_ctrl;
      t_lock;
      t_lost;
      t_pump;
      end_of_test;
   end
endmodule // rsl_synth_divider_lock_detect_tb
`default_nettype wire
